// [design/efcs_pkg.sv]
// Constants, codes and types shared by the flash command sequencer files
package efcs_pkg;

  // Command codes and keys carried in general registers
  localparam logic [11:0] CMD_SINGLE_HI = 12'h55A;
  localparam logic [11:0] CMD_DOUBLE_HI = 12'hDD4;
  localparam logic [11:0] CMD_BLOCK_HI  = 12'hAA5;
  localparam logic [15:0] CMD_ERASE     = 16'hEEEE;
  localparam logic [15:0] CMD_PROTECT   = 16'hCCCC;
  localparam logic [15:0] CMD_STATUS    = 16'h7777;
  localparam logic [15:0] KEY_A         = 16'h5555;
  localparam logic [15:0] KEY_B         = 16'h3333;
  localparam logic [15:0] KEY_C         = 16'hAAAA;

  // Result codes returned in general register 0
  localparam logic [7:0] ERR_OK     = 8'h00;
  localparam logic [7:0] ERR_VPP    = 8'h02;
  localparam logic [7:0] ERR_PROG   = 8'h03;
  localparam logic [7:0] ERR_ADDR   = 8'h04;
  localparam logic [7:0] ERR_PERIOD = 8'h05;
  localparam logic [7:0] ERR_STACK  = 8'h06;
  localparam logic [7:0] ERR_BANK   = 8'h07;
  localparam logic [7:0] ERR_ERASE1 = 8'h08;
  localparam logic [7:0] ERR_SRC    = 8'h09;
  localparam logic [7:0] ERR_COUNT  = 8'h0A;
  localparam logic [7:0] ERR_CLOCK  = 8'h0B;
  localparam logic [7:0] ERR_ERASE2 = 8'h0C;
  localparam logic [7:0] ERR_CMD    = 8'hFF;

  // Parameter limits
  localparam logic [15:0] MIN_STACK   = 16'h0032;
  localparam logic [15:0] PERIOD_MIN  = 16'h001E;
  localparam logic [15:0] PERIOD_MAX  = 16'h01F4;
  localparam logic [16:0] BLOCK_MAX_D = 17'h04000;
  localparam logic [16:0] SRC_LIMIT   = 17'h04000;
  localparam logic [15:0] LAST_BANK   = 16'h0003;

  // CPU address map of the array
  localparam logic [23:0] SEG0_LOW_END  = 24'h008000;
  localparam logic [23:0] SEG0_HIGH_BAS = 24'h018000;
  localparam logic [23:0] SEG1_BASE     = 24'h010000;
  localparam logic [23:0] FLASH_TOP     = 24'h050000;

  // Bank bounds as array byte offsets (first and last word)
  localparam logic [17:0] BANK1_OFF  = 18'h04000;
  localparam logic [17:0] BANK2_OFF  = 18'h10000;
  localparam logic [17:0] BANK3_OFF  = 18'h28000;
  localparam logic [17:0] BANK0_LAST = 18'h03FFC;
  localparam logic [17:0] BANK1_LAST = 18'h0FFFC;
  localparam logic [17:0] BANK2_LAST = 18'h27FFC;
  localparam logic [17:0] BANK3_LAST = 18'h3FFFC;
  localparam logic [17:0] HALF_STEP  = 18'h00002;
  localparam logic [17:0] WORD_STEP  = 18'h00004;

  // Array geometry: 32-bit words, two 16-bit halves
  localparam int          ARRAY_AW    = 16;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [1:0]  BE_LOW      = 2'h1;
  localparam logic [1:0]  BE_HIGH     = 2'h2;
  localparam logic [1:0]  BE_BOTH     = 2'h3;

  // Timing: longest program and erase times at the system clock
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned PROG_MAX_US    = 1500;
  localparam int unsigned ERASE_MAX_S    = 15;
  localparam logic [31:0] PROG_MAX_CYC_D = 32'(PROG_MAX_US * CLK_MHZ);
  localparam logic [31:0] ERASE_MAX_CYC_D =
    32'(64'(ERASE_MAX_S) * 64'(CLK_MHZ) * 64'd1000000);
  localparam logic [3:0]  MAX_RETRY_D    = 4'h8;
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

  // Sequencer states
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_CHECK = 9'h002,
    S_SRC   = 9'h004,
    S_RD    = 9'h008,
    S_WR    = 9'h010,
    S_ERS   = 9'h020,
    S_VRD   = 9'h040,
    S_VCHK  = 9'h080,
    S_DONE  = 9'h100
  } efcs_state_e;

endpackage : efcs_pkg

// [design/efcs_array_if.sv]
// Port bundle between the sequencer and the flash array
`timescale 1ns/1ps
interface efcs_array_if #(parameter int AW = efcs_pkg::ARRAY_AW);
  logic [AW-1:0] addr;
  logic          we;
  logic [1:0]    be;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  modport ctrl (output addr, output we, output be, output wdata, input rdata);
  modport mem  (input addr, input we, input be, input wdata, output rdata);
endinterface : efcs_array_if

// [design/efcs_flash_array.sv]
// Flash cell array, 32-bit words, registered read data
`timescale 1ns/1ps
module efcs_flash_array #(
  parameter int AW = efcs_pkg::ARRAY_AW
) (
  input  wire logic   clk_sys_i,
  efcs_array_if.mem   arr
);
  logic [31:0] rdata_ff;

  // One store per half so each has a single writer; reads track the address
  generate
    for (genvar h = 0; h < 2; h++) begin : g_half
      logic [15:0] half_q [0:(1<<AW)-1];
      always_ff @(posedge clk_sys_i) begin
        if (arr.we && arr.be[h]) begin
          half_q[arr.addr] <= arr.wdata[16*h +: 16];
        end
        rdata_ff[16*h +: 16] <= half_q[arr.addr];
      end
    end
  endgenerate

  assign arr.rdata = rdata_ff;
endmodule : efcs_flash_array

// [design/efcs_sequencer.sv]
// Flash program/erase command sequencer with unlock, checks and protection
// Notes on behaviour
// - Array read as 32-bit wide words
// - Four banks 16K/48K/96K/96K, erased independently
// - Segment 0 bank address decoding
// - Low banks mapped to segment 0 or 1
// - Protection blocks reads not from flash
// - Start on direct then indirect even write
// - Result into register 0, resume caller
// - Require 50 free stack words first
// - Multiply/divide registers overwritten by commands
// - Program codes with segment nibble, period
// - Erase code, key, bank twice
// - Protection set keys; status command code
// - Validate, decode, then execute
// - Verify cells and retry while programming
// - Failure returns specific cause code
// - Program and erase time limits
// - Result code values
// - Block covers at most one page
// - Erase needs equal bank in two registers
`timescale 1ns/1ps
module efcs_sequencer
  import efcs_pkg::*;
#(
  parameter logic [31:0] PROG_MAX_CYC  = efcs_pkg::PROG_MAX_CYC_D,
  parameter logic [31:0] ERASE_MAX_CYC = efcs_pkg::ERASE_MAX_CYC_D,
  parameter logic [3:0]  MAX_RETRY     = efcs_pkg::MAX_RETRY_D
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        map_seg1_i,
  input  wire logic        vpp_ok_i,
  input  wire logic        pll_fault_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_wr_indirect_i,
  input  wire logic [23:0] cpu_wr_addr_i,
  input  wire logic [15:0] gr0_i,
  input  wire logic [15:0] gr1_i,
  input  wire logic [15:0] gr2_i,
  input  wire logic [15:0] gr3_i,
  input  wire logic [15:0] gr4_i,
  input  wire logic [15:0] stack_free_words_i,
  output logic             src_req_o,
  output logic [15:0]      src_addr_o,
  input  wire logic [15:0] src_data_i,
  input  wire logic        src_valid_i,
  input  wire logic        rd_req_i,
  input  wire logic        rd_from_flash_i,
  input  wire logic [23:0] rd_addr_i,
  output logic             rd_ready_o,
  output logic             rd_valid_o,
  output logic [31:0]      rd_data_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             r0_we_o,
  output logic [15:0]      r0_result_o,
  output logic             md_we_o,
  output logic [15:0]      md_high_o,
  output logic [15:0]      md_low_o,
  output logic [15:0]      md_ctrl_o,
  output logic             user_protection_bit_o,
  output logic             map_seg1_o
);
  import efcs_pkg::*;

  // Pin synchronisers: map strap, supply good, clock fault
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] pin_raw;
  assign pin_raw = {pll_fault_i, vpp_ok_i, map_seg1_i};
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_ff[i] <= 1'b0;
          sync2_ff[i] <= 1'b0;
        end else begin
          sync1_ff[i] <= pin_raw[i];
          sync2_ff[i] <= sync1_ff[i];
        end
      end
    end
  endgenerate
  logic vpp_ok;
  logic pll_fault;
  assign vpp_ok    = sync2_ff[1];
  assign pll_fault = sync2_ff[2];

  // Strap caught once, after the synchroniser has settled
  logic [1:0] strap_cnt_ff;
  logic       map_seg1_ff;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_ff <= 2'h0;
      map_seg1_ff  <= 1'b0;
    end else if (strap_cnt_ff != STRAP_SETTLE) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff + 2'h1 == STRAP_SETTLE) begin
        map_seg1_ff <= sync2_ff[0];
      end
    end
  end
  assign map_seg1_o = map_seg1_ff;

  // CPU address to array byte offset; bit 18 flags a hit
  function automatic logic [18:0] flash_map(input logic [23:0] a, input logic seg1);
    logic [23:0] rel;
    rel = a - SEG1_BASE;
    if (seg1) begin
      flash_map = {(a >= SEG1_BASE) && (a < FLASH_TOP), rel[17:0]};
    end else if (a < SEG0_LOW_END) begin
      flash_map = {1'b1, a[17:0]};
    end else begin
      flash_map = {(a >= SEG0_HIGH_BAS) && (a < FLASH_TOP), rel[17:0]};
    end
  endfunction : flash_map

  efcs_state_e state_ff;
  efcs_state_e nxt_state;
  logic        armed_ff;
  logic [23:0] arm_addr_ff;
  logic [15:0] c0_ff, c1_ff, c2_ff, c3_ff, c4_ff;
  logic [17:0] off_ff;
  logic [17:0] last_ff;
  logic [13:0] cnt_ff;
  logic [15:0] src_ff;
  logic [15:0] data_ff;
  logic [3:0]  retry_ff;
  logic [31:0] tmo_ff;
  logic [7:0]  code_ff;
  logic        prot_ff;
  logic        md_wr_ff;

  // Unlock: direct even write into flash, then indirect to same address
  logic [18:0] wr_map;
  logic        arm_ok;
  logic        unlock_go;
  assign wr_map    = flash_map(cpu_wr_addr_i, map_seg1_ff);
  assign arm_ok    = cpu_wr_i && !cpu_wr_indirect_i && wr_map[18] && !cpu_wr_addr_i[0];
  assign unlock_go = (state_ff == S_IDLE) && cpu_wr_i && cpu_wr_indirect_i
                     && armed_ff && (cpu_wr_addr_i == arm_addr_ff);

  // Any other write between the two breaks the sequence
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      armed_ff    <= 1'b0;
      arm_addr_ff <= 24'h000000;
    end else if (cpu_wr_i) begin
      armed_ff    <= arm_ok && (state_ff == S_IDLE);
      arm_addr_ff <= cpu_wr_addr_i;
    end
  end

  // Command decode on the captured registers
  logic is_single, is_double, is_block, is_erase, is_prot, is_stat, is_prog;
  assign is_single = c0_ff[15:4] == CMD_SINGLE_HI;
  assign is_double = c0_ff[15:4] == CMD_DOUBLE_HI;
  assign is_block  = c0_ff[15:4] == CMD_BLOCK_HI;
  assign is_erase  = (c0_ff == CMD_ERASE) && (c1_ff == KEY_A);
  assign is_prot   = (c0_ff == CMD_PROTECT) && (c1_ff == KEY_A)
                     && (c2_ff == KEY_B) && (c3_ff == KEY_C);
  assign is_stat   = c0_ff == CMD_STATUS;
  assign is_prog   = is_single || is_double || is_block;

  // Parameter checks
  logic [18:0] beg_map, end_map;
  logic [16:0] blk_d;
  logic        addr_ok, cnt_ok, src_ok, bank_ok, period_ok, stack_ok;
  assign beg_map   = flash_map({4'h0, c0_ff[3:0], c1_ff}, map_seg1_ff);
  assign end_map   = flash_map({4'h0, c0_ff[3:0], c2_ff}, map_seg1_ff);
  assign blk_d     = {1'b0, c2_ff} - {1'b0, c1_ff};
  assign addr_ok   = beg_map[18] && !c1_ff[0];
  assign cnt_ok    = (c2_ff >= c1_ff) && (blk_d <= BLOCK_MAX_D)
                     && end_map[18] && !c2_ff[0];
  assign src_ok    = ({2'b00, c3_ff} + {1'b0, blk_d}) < {1'b0, SRC_LIMIT};
  assign bank_ok   = (c2_ff == c3_ff) && (c2_ff <= LAST_BANK);
  assign period_ok = (c4_ff >= PERIOD_MIN) && (c4_ff <= PERIOD_MAX);
  assign stack_ok  = stack_free_words_i >= MIN_STACK;

  // First failing check wins; zero means go ahead
  logic [7:0] chk_code;
  assign chk_code =
    !(is_prog || is_erase || is_prot || is_stat) ? ERR_CMD :
    is_stat                                       ? ERR_OK :
    !stack_ok                                     ? ERR_STACK :
    !period_ok                                    ? ERR_PERIOD :
    !vpp_ok                                       ? ERR_VPP :
    (is_erase && !bank_ok)                        ? ERR_BANK :
    (is_prog && !addr_ok)                         ? ERR_ADDR :
    (is_block && !cnt_ok)                         ? ERR_COUNT :
    (is_block && !src_ok)                         ? ERR_SRC : ERR_OK;

  // Erase range of the selected bank
  logic [17:0] ers_first, ers_last;
  assign ers_first = (c2_ff[1:0] == 2'h0) ? 18'h00000 :
                     (c2_ff[1:0] == 2'h1) ? BANK1_OFF :
                     (c2_ff[1:0] == 2'h2) ? BANK2_OFF : BANK3_OFF;
  assign ers_last  = (c2_ff[1:0] == 2'h0) ? BANK0_LAST :
                     (c2_ff[1:0] == 2'h1) ? BANK1_LAST :
                     (c2_ff[1:0] == 2'h2) ? BANK2_LAST : BANK3_LAST;

  // Array port: sequencer owns it while busy, CPU reads otherwise
  efcs_array_if #(.AW(ARRAY_AW)) arr ();
  logic        exec;
  logic        erasing;
  logic [18:0] rd_map;
  logic [15:0] cur_half;
  logic        verify_ok;
  logic        timed_out;
  assign exec      = (state_ff != S_IDLE) && (state_ff != S_CHECK) && (state_ff != S_DONE);
  assign erasing   = c0_ff == CMD_ERASE;
  assign rd_map    = flash_map(rd_addr_i, map_seg1_ff);
  assign arr.addr  = (state_ff == S_IDLE) ? rd_map[17:2] : off_ff[17:2];
  assign arr.we    = (state_ff == S_WR) || (state_ff == S_ERS);
  assign arr.be    = (state_ff == S_ERS) ? BE_BOTH : (off_ff[1] ? BE_HIGH : BE_LOW);
  assign cur_half  = off_ff[1] ? arr.rdata[31:16] : arr.rdata[15:0];
  // Cells only clear bits, so the new half is old AND wanted
  assign arr.wdata = (state_ff == S_ERS) ? ERASED_WORD :
                     {cur_half & data_ff, cur_half & data_ff};
  assign verify_ok = erasing ? (arr.rdata == ERASED_WORD) : (cur_half == data_ff);
  assign timed_out = tmo_ff >= (erasing ? ERASE_MAX_CYC : PROG_MAX_CYC);

  efcs_flash_array #(.AW(ARRAY_AW)) u_array (
    .clk_sys_i (clk_sys_i),
    .arr       (arr)
  );

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:  if (unlock_go) nxt_state = S_CHECK;
      S_CHECK: begin
        if (chk_code != ERR_OK || is_stat || is_prot) nxt_state = S_DONE;
        else if (is_erase) nxt_state = S_ERS;
        else if (is_block) nxt_state = S_SRC;
        else nxt_state = S_RD;
      end
      S_SRC:   if (src_valid_i) nxt_state = S_RD;
      S_RD:    nxt_state = S_WR;
      S_WR:    nxt_state = S_VRD;
      S_ERS:   nxt_state = S_VRD;
      S_VRD:   nxt_state = S_VCHK;
      S_VCHK: begin
        if (!verify_ok) begin
          if (retry_ff == MAX_RETRY) nxt_state = S_DONE;
          else nxt_state = erasing ? S_ERS : S_WR;
        end else if (erasing) begin
          nxt_state = (off_ff == last_ff) ? S_DONE : S_ERS;
        end else if (cnt_ff == 14'h0000) begin
          nxt_state = S_DONE;
        end else begin
          nxt_state = is_block ? S_SRC : S_RD;
        end
      end
      S_DONE:  nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
    if (exec && (timed_out || pll_fault)) nxt_state = S_DONE;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) state_ff <= S_IDLE;
    else state_ff <= nxt_state;
  end

  // Capture the command registers at the trigger point
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      {c0_ff, c1_ff, c2_ff, c3_ff, c4_ff} <= '0;
    end else if (unlock_go) begin
      {c0_ff, c1_ff, c2_ff, c3_ff, c4_ff} <= {gr0_i, gr1_i, gr2_i, gr3_i, gr4_i};
    end
  end

  // Walk pointers, data and retry count
  logic adv;
  assign adv = (state_ff == S_VCHK) && verify_ok;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      off_ff   <= 18'h00000;
      last_ff  <= 18'h00000;
      cnt_ff   <= 14'h0000;
      src_ff   <= 16'h0000;
      data_ff  <= 16'h0000;
      retry_ff <= 4'h0;
    end else if (state_ff == S_CHECK) begin
      off_ff   <= is_erase ? ers_first : beg_map[17:0];
      last_ff  <= ers_last;
      cnt_ff   <= is_block ? blk_d[14:1] : {13'h0000, is_double};
      src_ff   <= c3_ff;
      data_ff  <= c2_ff;
      retry_ff <= 4'h0;
    end else if (state_ff == S_SRC && src_valid_i) begin
      data_ff <= src_data_i;
    end else if (state_ff == S_VCHK && !verify_ok) begin
      retry_ff <= retry_ff + 4'h1;
    end else if (adv) begin
      off_ff   <= off_ff + (erasing ? WORD_STEP : HALF_STEP);
      cnt_ff   <= cnt_ff - 14'h0001;
      src_ff   <= src_ff + 16'h0002;
      data_ff  <= c3_ff; // Second half of a double word
      retry_ff <= 4'h0;
    end
  end

  // Time limit restarts per program half word, runs whole bank for erase
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) tmo_ff <= 32'h00000000;
    else if (!exec || (adv && !erasing)) tmo_ff <= 32'h00000000;
    else tmo_ff <= tmo_ff + 32'h00000001;
  end

  // Result code and protection bit
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      code_ff <= ERR_OK;
      prot_ff <= 1'b0;
    end else if (state_ff == S_CHECK) begin
      code_ff <= chk_code;
      if (is_prot && chk_code == ERR_OK) prot_ff <= 1'b1;
    end else if (exec && pll_fault) begin
      code_ff <= ERR_CLOCK;
    end else if (exec && timed_out) begin
      code_ff <= erasing ? ERR_ERASE2 : ERR_PROG;
    end else if (state_ff == S_VCHK && !verify_ok && retry_ff == MAX_RETRY) begin
      code_ff <= erasing ? ERR_ERASE1 : ERR_PROG;
    end
  end

  // Scratch use of the multiply/divide registers, written at completion
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      md_high_o <= 16'h0000;
      md_low_o  <= 16'h0000;
      md_ctrl_o <= 16'h0000;
    end else if (state_ff == S_DONE) begin
      md_high_o <= data_ff;
      md_low_o  <= off_ff[15:0];
      md_ctrl_o <= {12'h000, retry_ff};
    end
  end

  // CPU reads: blocked for code outside the flash when protected
  logic rd_take;
  logic rd_block_ff;
  assign rd_take = rd_req_i && (state_ff == S_IDLE);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_valid_o  <= 1'b0;
      rd_block_ff <= 1'b1;
    end else begin
      rd_valid_o  <= rd_take;
      if (rd_take) rd_block_ff <= !rd_map[18] || (prot_ff && !rd_from_flash_i);
    end
  end

  assign rd_ready_o            = state_ff == S_IDLE;
  assign rd_data_o             = rd_block_ff ? 32'h00000000 : arr.rdata;
  assign src_req_o             = state_ff == S_SRC;
  assign src_addr_o            = src_ff;
  assign busy_o                = state_ff != S_IDLE;
  assign done_o                = state_ff == S_DONE;
  assign r0_we_o               = state_ff == S_DONE;
  assign r0_result_o           = {8'h00, code_ff};
  assign md_we_o               = md_wr_ff;
  assign user_protection_bit_o = prot_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) md_wr_ff <= 1'b0;
    else md_wr_ff <= state_ff == S_DONE;
  end

  // Checks on the sequencer's own behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_unlock;
    cpu_wr_i && !cpu_wr_indirect_i ##1 cpu_wr_i && cpu_wr_indirect_i;
  endsequence
  property p_start_unlock;
    $rose(busy_o) |-> $past(cpu_wr_i && cpu_wr_indirect_i) && $past(armed_ff);
  endproperty
  a_start_unlock: assert property (p_start_unlock)
    else $error("command started without unlock");
  property p_done_result;
    $rose(busy_o) && !erasing && !is_block |-> ##[1:1000] done_o;
  endproperty
  a_done_result: assert property (p_done_result)
    else $error("no progress after start");
  property p_stack;
    (state_ff == S_CHECK) && is_prog && !stack_ok |=> done_o && r0_result_o == 16'h0006;
  endproperty
  a_stack: assert property (p_stack)
    else $error("stack shortage not reported");
  property p_unknown;
    (state_ff == S_CHECK) && !(is_prog || is_erase || is_prot || is_stat)
      |=> done_o && r0_result_o == 16'h00FF;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown command not reported");
  property p_bank;
    (state_ff == S_CHECK) && is_erase && stack_ok && period_ok && vpp_ok
      && (c2_ff != c3_ff) |=> r0_result_o == 16'h0007;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank mismatch accepted");
  property p_protect;
    rd_take && prot_ff && !rd_from_flash_i |=> rd_valid_o && rd_data_o == 32'h00000000;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected read leaked data");
  property p_md;
    done_o |=> md_we_o ##1 !md_we_o;
  endproperty
  a_md: assert property (p_md)
    else $error("md registers not written once");
  property p_retry;
    (state_ff == S_VCHK) && !verify_ok && retry_ff < MAX_RETRY && !timed_out
      && !pll_fault |=> (state_ff == S_WR || state_ff == S_ERS) ##2 state_ff == S_VCHK;
  endproperty
  a_retry: assert property (p_retry)
    else $error("verify failure not retried");
  property p_order;
    (state_ff == S_CHECK) && chk_code != ERR_OK |=> done_o ##1 !busy_o;
  endproperty
  a_order: assert property (p_order)
    else $error("failed check still executed");
endmodule : efcs_sequencer

// [verif/efcs_cpu_model.sv]
// CPU side model: unlock writes and block source replies
`timescale 1ns/1ps
module efcs_cpu_model (
  input  wire logic        clk_sys_i,
  input  wire logic        src_req_i,
  input  wire logic [15:0] src_addr_i,
  output logic             cpu_wr_o,
  output logic             cpu_ind_o,
  output logic [23:0]      cpu_addr_o,
  output logic             src_valid_o,
  output logic [15:0]      src_data_o
);
  initial begin
    cpu_wr_o = 1'b0;
    cpu_ind_o = 1'b0;
    cpu_addr_o = 24'h000000;
    src_valid_o = 1'b0;
    src_data_o = 16'h0000;
  end
  // Source word answers on the next falling edge; word is the inverted source address
  always @(negedge clk_sys_i) begin
    src_valid_o <= src_req_i;
    src_data_o <= ~src_addr_i;
  end
  // Direct write then indirect write to the same even address
  task automatic unlock(input logic [23:0] a);
    @(negedge clk_sys_i);
    cpu_wr_o = 1'b1;
    cpu_ind_o = 1'b0;
    cpu_addr_o = a;
    @(negedge clk_sys_i);
    cpu_ind_o = 1'b1;
    @(negedge clk_sys_i);
    cpu_wr_o = 1'b0;
    cpu_addr_o = ~a;
  endtask : unlock
endmodule : efcs_cpu_model

// [verif/tb_top.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module tb_top;
  import efcs_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, vpp_ok_i = 1'b1;
  logic pll_i = 1'b0, seg1_i = 1'b0;
  logic rd_req_i = 1'b0, rd_from_flash_i = 1'b0;
  logic [23:0] rd_addr_i = 24'h000000;
  logic [15:0] gr [5] = '{5{16'h0000}};
  logic [15:0] stack_i = 16'h0064, w;
  logic [31:0] seed = 32'hBE763300;
  logic cwr, cind, sreq, sval, rdy, rval, busy, done, upb, r0we, mseg;
  logic [23:0] caddr;
  logic [15:0] sdata, saddr, res;
  logic [31:0] rdata;
  int num_errors = 0, compares = 0;
  efcs_sequencer #(.PROG_MAX_CYC(32'h000000C8), .ERASE_MAX_CYC(32'h00009C40))
  efcs_sequencer_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .map_seg1_i(seg1_i),
    .vpp_ok_i(vpp_ok_i), .pll_fault_i(pll_i), .cpu_wr_i(cwr), .cpu_wr_indirect_i(cind),
    .cpu_wr_addr_i(caddr), .gr0_i(gr[0]), .gr1_i(gr[1]), .gr2_i(gr[2]), .gr3_i(gr[3]),
    .gr4_i(gr[4]), .stack_free_words_i(stack_i), .src_req_o(sreq), .src_addr_o(saddr),
    .src_data_i(sdata), .src_valid_i(sval), .rd_req_i(rd_req_i),
    .rd_from_flash_i(rd_from_flash_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rdy),
    .rd_valid_o(rval), .rd_data_o(rdata), .busy_o(busy), .done_o(done), .r0_we_o(r0we),
    .r0_result_o(res), .md_we_o(), .md_high_o(), .md_low_o(), .md_ctrl_o(),
    .user_protection_bit_o(upb), .map_seg1_o(mseg));
  efcs_cpu_model efcs_cpu_model_inst (.clk_sys_i(clk_sys_i), .src_req_i(sreq),
    .src_addr_i(saddr), .cpu_wr_o(cwr), .cpu_ind_o(cind), .cpu_addr_o(caddr),
    .src_valid_o(sval), .src_data_o(sdata));
  // 125 MHz clock
  always #4 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Blocked reads from RAM code see zero
  function automatic logic [31:0] exp_rd(input logic p, f, input logic [15:0] l, h);
    return (p & ~f) ? 32'h00000000 : {h, l};
  endfunction : exp_rd
  task automatic cmp_code(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected code at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_code
  task automatic cmp_data(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected data at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_data
  // Load registers, unlock, wait for completion under a bound
  task automatic cmd(input logic [15:0] a, b, c, d, e, input logic [7:0] x, input int lim);
    int n;
    @(negedge clk_sys_i);
    gr = '{a, b, c, d, e};
    efcs_cpu_model_inst.unlock(24'h000100);
    cmp_data({30'h00000000, busy, rdy}, 32'h00000002);
    n = 0;
    while (done !== 1'b1 && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= lim) num_errors++;
    cmp_code(res[7:0], x);
    cmp_data({31'h00000000, r0we}, 32'h00000001);
  endtask : cmd
  task automatic rd(input logic [23:0] a, input logic f, input logic [31:0] x);
    @(negedge clk_sys_i);
    rd_req_i = 1'b1;
    rd_from_flash_i = f;
    rd_addr_i = a;
    @(negedge clk_sys_i);
    rd_req_i = 1'b0;
    cmp_data({31'h00000000, rval}, 32'h00000001);
    cmp_data(rdata, x);
  endtask : rd
  task automatic test_done;
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Hang guard, well past the longest erase
  initial begin
    #720000;
    num_errors++;
    test_done;
  end
  // Main sequence: status and refusals first, then erase, program, a count refusal, block program, protect
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    seed = lfsr(seed);
    cmd(CMD_STATUS, seed[15:0], 0, 0, 16'h0028, ERR_OK, 20);
    cmd({4'h1, seed[27:16]}, 0, 0, 0, 16'h0028, ERR_CMD, 20);
    stack_i = MIN_STACK - 16'h0001;
    cmd(CMD_ERASE, KEY_A, 0, 0, 16'h0028, ERR_STACK, 20);
    stack_i = MIN_STACK;
    cmd(CMD_ERASE, KEY_A, 0, 0, PERIOD_MIN - 16'h0001, ERR_PERIOD, 20);
    cmd(CMD_ERASE, KEY_A, 16'h0001, 16'h0002, 16'h0028, ERR_BANK, 20);
    vpp_ok_i = 1'b0;
    cmd(CMD_ERASE, KEY_A, 0, 0, 16'h0028, ERR_VPP, 20);
    vpp_ok_i = 1'b1;
    cmd({CMD_SINGLE_HI, 4'h0}, 16'h0005, 0, 0, 16'h0028, ERR_ADDR, 20);
    pll_i = 1'b1;
    cmd({CMD_SINGLE_HI, 4'h0}, 16'h0004, 0, 0, 16'h0028, ERR_CLOCK, 20);
    pll_i = 1'b0;
    cmd(CMD_ERASE, KEY_A, 0, 0, 16'h0028, ERR_OK, 30000);
    seed = lfsr(seed);
    w = seed[15:0];
    cmd({CMD_SINGLE_HI, 4'h0}, 16'h0004, w, 0, 16'h0028, ERR_OK, 500);
    rd(24'h000004, 1'b0, exp_rd(1'b0, 1'b0, w, 16'hFFFF));
    seed = lfsr(seed);
    cmd({CMD_DOUBLE_HI, 4'h0}, 16'h0008, seed[15:0], seed[31:16], 16'h0028, ERR_OK, 500);
    rd(24'h000008, 1'b0, exp_rd(1'b0, 1'b0, seed[15:0], seed[31:16]));
    cmd({CMD_BLOCK_HI, 4'h0}, 16'h0012, 16'h0010, 16'h0100, 16'h0028, ERR_COUNT, 20);
    cmd({CMD_BLOCK_HI, 4'h0}, 16'h0010, 16'h0012, 16'h0100, 16'h0028, ERR_OK, 500);
    rd(24'h000010, 1'b0, exp_rd(1'b0, 1'b0, ~16'h0100, ~16'h0102));
    cmd(CMD_PROTECT, KEY_A, KEY_B, KEY_C, 16'h0028, ERR_OK, 20);
    cmp_data({31'h00000000, upb}, 32'h00000001);
    rd(24'h000008, 1'b0, exp_rd(1'b1, 1'b0, seed[15:0], seed[31:16]));
    rd(24'h000008, 1'b1, exp_rd(1'b1, 1'b1, seed[15:0], seed[31:16]));
    // Second reset with the strap set: low banks move to segment 1
    seg1_i = 1'b1;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    cmp_data({30'h00000000, mseg, upb}, 32'h00000002);
    rd(24'h010008, 1'b0, exp_rd(1'b0, 1'b0, seed[15:0], seed[31:16]));
    test_done;
  end
endmodule : tb_top
